/* logic/stgrp_pkg.sv */
// Package holding constants of the status register groups block
// How it works
// - Four groups; standard event group lives elsewhere
// - Three groups each hold condition, mask, event
// - Activity bits: calibration 0, step 3, reading 4
// - Activity event latches, clears when read
// - Activity condition shows live state
// - Activity summary is OR of masked events
// - Activity and alarm masks take 0 to 32727
// - Alarm bits: voltage 0, current 1, temp 3
// - Alarm bits: inhibit 9, rms limit 12
// - Alarm event latches, clears when read
// - Alarm condition shows live state
// - Alarm summary, status bit 3, includes phases
// - Phase event latches filtered edges, read clears
// - Phase masks take 0 to 32767
`default_nettype none
package stgrp_pkg;

  // ==========================================================
  // Register selection codes for the command port
  localparam logic [3:0] REG_ACT_COND = 4'h0;
  localparam logic [3:0] REG_ACT_EVENT = 4'h1;
  localparam logic [3:0] REG_ACT_MASK = 4'h2;
  localparam logic [3:0] REG_ALM_COND = 4'h3;
  localparam logic [3:0] REG_ALM_EVENT = 4'h4;
  localparam logic [3:0] REG_ALM_MASK = 4'h5;
  localparam logic [3:0] REG_PH_COND = 4'h6;
  localparam logic [3:0] REG_PH_EVENT = 4'h7;
  localparam logic [3:0] REG_PH_MASK = 4'h8;
  localparam logic [3:0] REG_PH_RISE = 4'h9;
  localparam logic [3:0] REG_PH_FALL = 4'hA;

  // ==========================================================
  // Field layouts
  localparam int unsigned REG_W = 16;
  localparam int unsigned PHASES = 3;
  localparam logic [15:0] ACT_USED = 16'h0019;
  localparam logic [15:0] ALM_USED = 16'h120B;
  localparam logic [15:0] ACT_MASK_MAX = 16'h7FD7;
  localparam logic [15:0] ALM_MASK_MAX = 16'h7FD7;
  localparam logic [15:0] PH_MASK_MAX = 16'h7FFF;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] RISE_RESET = 16'hFFFF;
  localparam logic [15:0] FALL_RESET = 16'h0000;
  localparam int unsigned ALARM_SUM_BIT = 3;

  typedef enum {
    STGRP_IDLE,
    STGRP_ANSWER
  } stgrp_state_t;

endpackage
`default_nettype wire

/* logic/stgrp_event_latch.sv */
// One condition/event pair with edge filters and clear on read
`timescale 1ns/1ps
`default_nettype none
module stgrp_event_latch (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] cond,
  input wire logic [15:0] used,
  input wire logic [15:0] riseEn,
  input wire logic [15:0] fallEn,
  input wire logic readClear,
  output logic [15:0] event_r
);
  import stgrp_pkg::*;

  logic [15:0] condPrev_r;
  logic [15:0] hit;

  always_ff @(posedge clock) begin
    if (rst) begin
      condPrev_r <= 16'h0000;
    end else begin
      condPrev_r <= cond & used;
    end
  end

  // Edge detect on filtered condition
  assign hit = (((cond & used) & ~condPrev_r) & riseEn) |
               ((~(cond & used) & condPrev_r) & fallEn);

  // New hit wins over a clearing read so no event is lost
  always_ff @(posedge clock) begin
    if (rst) begin
      event_r <= 16'h0000;
    end else if (readClear) begin
      event_r <= hit & used;
    end else begin
      event_r <= (event_r | hit) & used;
    end
  end

  a_event_holds: assert property (@(posedge clock) disable iff (rst)
    (event_r != 16'h0000 && !readClear) |=>
      ((event_r & $past(event_r)) == $past(event_r)))
    else $error("event bit lost without read");
  a_unused_zero: assert property (@(posedge clock) disable iff (rst)
    (event_r & ~used) == 16'h0000)
    else $error("unused event bit set");
endmodule
`default_nettype wire

/* logic/stgrp_phase_mem.sv */
// Small per-phase word store with registered read data
`timescale 1ns/1ps
`default_nettype none
module stgrp_phase_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic wen,
  input wire logic [1:0] raddr,
  input wire logic [15:0] resetVal,
  output logic [15:0] rdata_r,
  output logic [47:0] all
);
  import stgrp_pkg::*;

  logic [15:0] mem [PHASES];

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < PHASES; i++) begin
        mem[i] <= resetVal;
      end
    end else if (wen && waddr < 2'(PHASES)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (raddr < 2'(PHASES)) begin
      rdata_r <= mem[raddr];
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign all = {mem[2], mem[1], mem[0]};
endmodule
`default_nettype wire

/* logic/stgrp_top.sv */
// Status register groups: activity, alarm and per-phase alarm
`timescale 1ns/1ps
`default_nettype none
module stgrp_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] activityIn,
  input wire logic [15:0] alarmIn,
  input wire logic [47:0] phaseAlarmIn,
  input wire logic [1:0] phaseSelect,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [3:0] cmdReg,
  input wire logic [15:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic activitySummary,
  output logic alarmSummary,
  output logic [7:0] statusBits
);
  import stgrp_pkg::*;

  // ==========================================================
  // Synchronisers for live conditions from the source
  logic [15:0] actS1_r, actS2_r, actS3_r, actLive_r;
  logic [15:0] almS1_r, almS2_r, almS3_r, almLive_r;
  logic [47:0] phS1_r, phS2_r, phS3_r, phLive_r;

  // A change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      actS1_r <= 16'h0000;
      actS2_r <= 16'h0000;
      actS3_r <= 16'h0000;
      actLive_r <= 16'h0000;
    end else begin
      actS1_r <= activityIn;
      actS2_r <= actS1_r;
      actS3_r <= actS2_r;
      actLive_r <= (actS2_r & actS3_r) |
                   (actLive_r & (actS2_r | actS3_r));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      almS1_r <= 16'h0000;
      almS2_r <= 16'h0000;
      almS3_r <= 16'h0000;
      almLive_r <= 16'h0000;
    end else begin
      almS1_r <= alarmIn;
      almS2_r <= almS1_r;
      almS3_r <= almS2_r;
      almLive_r <= (almS2_r & almS3_r) |
                   (almLive_r & (almS2_r | almS3_r));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phS1_r <= 48'h0;
      phS2_r <= 48'h0;
      phS3_r <= 48'h0;
      phLive_r <= 48'h0;
    end else begin
      phS1_r <= phaseAlarmIn;
      phS2_r <= phS1_r;
      phS3_r <= phS2_r;
      phLive_r <= (phS2_r & phS3_r) | (phLive_r & (phS2_r | phS3_r));
    end
  end

  // ==========================================================
  // Command decode
  logic [15:0] actMask_r, almMask_r;
  logic take, isWr, isRd;
  stgrp_state_t state_r;

  assign cmdReady = (state_r == STGRP_IDLE);
  assign take = cmdValid && cmdReady;
  assign isWr = take && cmdWrite;
  assign isRd = take && !cmdWrite;

  function automatic logic [15:0] clampMask(input logic [15:0] v,
                                            input logic [15:0] lim);
    // Out of range writes are clipped to the limit
    clampMask = (v > lim) ? lim : v;
  endfunction

  always_ff @(posedge clock) begin
    if (rst) begin
      actMask_r <= MASK_RESET;
    end else if (isWr && cmdReg == REG_ACT_MASK) begin
      actMask_r <= clampMask(cmdData, ACT_MASK_MAX);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      almMask_r <= MASK_RESET;
    end else if (isWr && cmdReg == REG_ALM_MASK) begin
      almMask_r <= clampMask(cmdData, ALM_MASK_MAX);
    end
  end

  // ==========================================================
  // Event latches for the three groups
  logic [15:0] actEvent, almEvent;
  logic [15:0] phEvent [PHASES];
  logic [47:0] phMaskAll, phRiseAll, phFallAll;
  logic [15:0] phMaskRd, phRiseRd, phFallRd;

  stgrp_event_latch uAct (
    .clock(clock),
    .rst(rst),
    .cond(actLive_r),
    .used(ACT_USED),
    .riseEn(16'hFFFF),
    .fallEn(16'h0000),
    .readClear(isRd && cmdReg == REG_ACT_EVENT),
    .event_r(actEvent)
  );

  stgrp_event_latch uAlm (
    .clock(clock),
    .rst(rst),
    .cond(almLive_r),
    .used(ALM_USED),
    .riseEn(16'hFFFF),
    .fallEn(16'h0000),
    .readClear(isRd && cmdReg == REG_ALM_EVENT),
    .event_r(almEvent)
  );

  // Phase-selected writes go only to the chosen phase
  stgrp_phase_mem uPhMask (
    .clock(clock),
    .rst(rst),
    .waddr(phaseSelect),
    .wdata(clampMask(cmdData, PH_MASK_MAX)),
    .wen(isWr && cmdReg == REG_PH_MASK),
    .raddr(phaseSelect),
    .resetVal(MASK_RESET),
    .rdata_r(phMaskRd),
    .all(phMaskAll)
  );

  stgrp_phase_mem uPhRise (
    .clock(clock),
    .rst(rst),
    .waddr(phaseSelect),
    .wdata(cmdData),
    .wen(isWr && cmdReg == REG_PH_RISE),
    .raddr(phaseSelect),
    .resetVal(RISE_RESET),
    .rdata_r(phRiseRd),
    .all(phRiseAll)
  );

  stgrp_phase_mem uPhFall (
    .clock(clock),
    .rst(rst),
    .waddr(phaseSelect),
    .wdata(cmdData),
    .wen(isWr && cmdReg == REG_PH_FALL),
    .raddr(phaseSelect),
    .resetVal(FALL_RESET),
    .rdata_r(phFallRd),
    .all(phFallAll)
  );

  for (genvar p = 0; p < PHASES; p++) begin : gPh
    stgrp_event_latch uPh (
      .clock(clock),
      .rst(rst),
      .cond(phLive_r[16*p +: 16]),
      .used(ALM_USED),
      .riseEn(phRiseAll[16*p +: 16]),
      .fallEn(phFallAll[16*p +: 16]),
      .readClear(isRd && cmdReg == REG_PH_EVENT &&
                 phaseSelect == 2'(p)),
      .event_r(phEvent[p])
    );
  end

  // ==========================================================
  // Summary bits
  logic phAny;
  always_comb begin
    phAny = 1'b0;
    for (int p = 0; p < PHASES; p++) begin
      phAny = phAny | (|(phEvent[p] & phMaskAll[16*p +: 16]));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      activitySummary <= 1'b0;
      alarmSummary <= 1'b0;
    end else begin
      activitySummary <= |(actEvent & actMask_r);
      alarmSummary <= (|(almEvent & almMask_r)) | phAny;
    end
  end

  always_comb begin
    statusBits = 8'h00;
    statusBits[ALARM_SUM_BIT] = alarmSummary;
  end

  // ==========================================================
  // Read path: answer one cycle after a taken read; writes get no answer
  logic [15:0] phSelCond, phSelEvent;
  always_comb begin
    phSelCond = 16'h0000;
    phSelEvent = 16'h0000;
    for (int p = 0; p < PHASES; p++) begin
      if (phaseSelect == 2'(p)) begin
        phSelCond = phLive_r[16*p +: 16] & ALM_USED;
        phSelEvent = phEvent[p];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= STGRP_IDLE;
    end else begin
      case (state_r)
        STGRP_IDLE: begin
          if (isRd) begin
            state_r <= STGRP_ANSWER;
          end
        end
        STGRP_ANSWER: state_r <= STGRP_IDLE;
        default: state_r <= STGRP_IDLE;
      endcase
    end
  end

  assign rspValid = (state_r == STGRP_ANSWER);

  // Phase memories answer a cycle late, so only their register code is held here
  logic [3:0] rdReg_r;
  logic [15:0] rdHold_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      rdReg_r <= REG_ACT_COND;
      rdHold_r <= 16'h0000;
    end else if (isRd) begin
      rdReg_r <= cmdReg;
      case (cmdReg)
        REG_ACT_COND: rdHold_r <= actLive_r & ACT_USED;
        REG_ACT_EVENT: rdHold_r <= actEvent;
        REG_ACT_MASK: rdHold_r <= actMask_r;
        REG_ALM_COND: rdHold_r <= almLive_r & ALM_USED;
        REG_ALM_EVENT: rdHold_r <= almEvent;
        REG_ALM_MASK: rdHold_r <= almMask_r;
        REG_PH_COND: rdHold_r <= phSelCond;
        REG_PH_EVENT: rdHold_r <= phSelEvent;
        default: rdHold_r <= 16'h0000;
      endcase
    end
  end

  always_comb begin
    case (rdReg_r)
      REG_PH_MASK: rspData = phMaskRd;
      REG_PH_RISE: rspData = phRiseRd;
      REG_PH_FALL: rspData = phFallRd;
      default: rspData = rdHold_r;
    endcase
  end

  // ==========================================================
  // Only a quiet condition lets the clear stand; a new edge wins
  sequence readEvent;
    isRd && cmdReg == REG_ACT_EVENT && $stable(actLive_r);
  endsequence

  a_act_clear: assert property (@(posedge clock) disable iff (rst)
    readEvent |=> (actEvent == 16'h0000))
    else $error("activity event not cleared by read");
  a_act_summary: assert property (@(posedge clock) disable iff (rst)
    activitySummary == $past(|(actEvent & actMask_r)))
    else $error("activity summary mismatch");
  a_mask_limit: assert property (@(posedge clock) disable iff (rst)
    actMask_r <= ACT_MASK_MAX && almMask_r <= ALM_MASK_MAX)
    else $error("mask above limit");
  a_mask_reset: assert property (@(posedge clock) disable iff (rst)
    $past(rst) |-> actMask_r == 16'h0000 && almMask_r == 16'h0000)
    else $error("mask not zero after reset");
  a_alarm_bit3: assert property (@(posedge clock) disable iff (rst)
    statusBits[3] == alarmSummary)
    else $error("status bit 3 not alarm summary");
  a_alarm_edge: assert property (@(posedge clock) disable iff (rst)
    (almLive_r[0] && !$past(almLive_r[0])) |-> ##1 almEvent[0])
    else $error("alarm event missed");
  a_cond_live: assert property (@(posedge clock) disable iff (rst)
    (isRd && cmdReg == REG_ALM_COND) |-> ##1
      rspValid && rspData == $past(almLive_r & ALM_USED))
    else $error("alarm condition read wrong");
  a_resp_once: assert property (@(posedge clock) disable iff (rst)
    rspValid |=> !rspValid)
    else $error("answer stood two cycles");
endmodule
`default_nettype wire

/* tb/stgrp_top_tb.sv */
// Self-checking bench for the status register groups block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module stgrp_top_tb;
  import stgrp_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] activityIn = 16'h0000;
  logic [15:0] alarmIn = 16'h0000;
  logic [47:0] phaseAlarmIn = 48'h0;
  logic [1:0] phaseSelect = 2'h0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [3:0] cmdReg = 4'h0;
  logic [15:0] cmdData = 16'h0000;
  logic cmdReady;
  logic rspValid;
  logic activitySummary;
  logic alarmSummary;
  logic [15:0] rspData;
  logic [7:0] statusBits;
  int fails = 0;
  int tests_run = 0;
  logic [15:0] expQ[$];
  string nameQ[$];
  logic [15:0] v;
  logic [15:0] used;
  logic [3:0] base;

  stgrp_top uut (
    .clock(clock),
    .rst(rst),
    .activityIn(activityIn),
    .alarmIn(alarmIn),
    .phaseAlarmIn(phaseAlarmIn),
    .phaseSelect(phaseSelect),
    .cmdValid(cmdValid),
    .cmdWrite(cmdWrite),
    .cmdReg(cmdReg),
    .cmdData(cmdData),
    .cmdReady(cmdReady),
    .rspValid(rspValid),
    .rspData(rspData),
    .activitySummary(activitySummary),
    .alarmSummary(alarmSummary),
    .statusBits(statusBits)
  );

  always #5 clock = ~clock;

  // ==========================================================
  // Checking and closing
  task automatic check(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Answers are matched in order; a stray answer is itself a fault
  always @(negedge clock) begin
    if (rspValid === 1'b1) begin
      `CHK("cmdReady", 1'b0, cmdReady);
      if (expQ.size() == 0) begin
        fails++;
        $display("mismatch rspValid expected 0 seen 1");
      end else begin
        `CHK(nameQ.pop_front(), expQ.pop_front(), rspData);
      end
    end
  end

  // ==========================================================
  // Command port tasks
  // A gap cycle follows every command, since a read blocks the next one
  task automatic cmd(input logic w, input logic [3:0] r,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clock);
    while (cmdReady !== 1'b1 && n < 20) begin
      n++;
      @(negedge clock);
    end
    if (n >= 20) begin
      fails++;
      $display("mismatch cmdReady expected 1 seen 0");
      finish_test();
    end
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdReg = r;
    cmdData = d;
    @(negedge clock);
    cmdValid = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [3:0] r, input logic [15:0] e,
                    input string n);
    expQ.push_back(e);
    nameQ.push_back(n);
    cmd(1'b0, r, 16'h0000);
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge clock);
  endtask

  task automatic sums(input logic a, input logic q);
    `CHK("activitySummary", a, activitySummary);
    `CHK("alarmSummary", q, alarmSummary);
    `CHK("statusBits", {4'h0, q, 3'h0}, statusBits);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    v = 16'($urandom(62));
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    rd(REG_ACT_MASK, MASK_RESET, "actMask");
    rd(REG_ALM_MASK, MASK_RESET, "almMask");
    rd(REG_PH_MASK, MASK_RESET, "phMask");
    rd(REG_ALM_EVENT, 16'h0000, "almEvent");
    rd(4'hF, 16'h0000, "unknownReg");
    sums(1'b0, 1'b0);
    $display("test reset done");
    // Activity group first, then alarm group: same layout of codes
    for (int g = 0; g < 2; g++) begin
      base = 4'(3 * g);
      used = (g == 1) ? ALM_USED : ACT_USED;
      v = 16'($urandom()) | 16'h0001;
      if (g == 1) alarmIn = v;
      else activityIn = v;
      wt(8);
      rd(base, v & used, "cond");
      cmd(1'b1, base + 4'h2, ACT_MASK_MAX);
      wt(2);
      sums(g == 0, g == 1);
      rd(base + 4'h2, (g == 1) ? ALM_MASK_MAX : ACT_MASK_MAX, "mask");
      rd(base + 4'h1, v & used, "event");
      wt(2);
      sums(1'b0, 1'b0);
      rd(base + 4'h1, 16'h0000, "event");
      cmd(1'b1, base + 4'h2, 16'h0000);
      activityIn = 16'h0000;
      alarmIn = 16'h0000;
      wt(8);
      rd(base + 4'h1, 16'h0000, "event");
      $display("test group %0d done", g);
    end
    for (int p = 0; p < 3; p++) begin
      phaseSelect = 2'(p);
      v = (16'($urandom()) & ALM_USED) | 16'h0002;
      phaseAlarmIn[16*p +: 16] = v;
      wt(8);
      rd(REG_PH_COND, v, "phCond");
      cmd(1'b1, REG_PH_MASK, PH_MASK_MAX);
      wt(2);
      sums(1'b0, 1'b1);
      rd(REG_PH_MASK, PH_MASK_MAX, "phMask");
      rd(REG_PH_EVENT, v, "phEvent");
      wt(2);
      sums(1'b0, 1'b0);
      cmd(1'b1, REG_PH_MASK, 16'h0000);
      phaseAlarmIn[16*p +: 16] = 16'h0000;
      wt(8);
      rd(REG_PH_EVENT, 16'h0000, "phEvent");
      $display("test phase %0d done", p);
    end
    // Falling filter only on phase 0; phase 3 selects nothing
    phaseAlarmIn = {3{16'h0001}};
    phaseSelect = 2'h3;
    wt(8);
    rd(REG_PH_COND, 16'h0000, "phNone");
    phaseSelect = 2'h0;
    rd(REG_PH_EVENT, 16'h0001, "phEvent");
    cmd(1'b1, REG_PH_RISE, 16'h0000);
    cmd(1'b1, REG_PH_FALL, 16'hFFFF);
    rd(REG_PH_RISE, 16'h0000, "phRiseEn");
    rd(REG_PH_FALL, 16'hFFFF, "phFallEn");
    phaseAlarmIn[15:0] = 16'h0000;
    wt(8);
    rd(REG_PH_EVENT, 16'h0001, "phFall");
    phaseAlarmIn[15:0] = 16'h0001;
    wt(8);
    rd(REG_PH_EVENT, 16'h0000, "phRise");
    $display("test filters done");
    wt(4);
    if (expQ.size() != 0) begin
      fails++;
      $display("mismatch answers expected 0 seen %0d", expQ.size());
    end
    finish_test();
  end

  initial begin
    #100000;
    fails++;
    $display("mismatch watchdog expected end seen hang");
    finish_test();
  end
endmodule
`default_nettype wire
